// >>> rtl/port_pin_config.sv
// pin configuration for ports 0..2: mode registers, pull-ups, pad drive
//
// Contract
// - ports 0,1 codes: 00 schmitt input, 01 open drain, 10 push-pull.
// - port 0 pins 7..4 code 11: buzzer, clock out, timer b, timer a.
// - code 11 on port 0 pins 3..0, port 1 pins 7..2 does nothing.
// - port 1 code 11: pin 1 serial data out, pin 0 serial clock.
// - port 2 codes: 00 input, 01 open drain, 10 push-pull.
// - port 2 code 11 gives pin to lcd segment, pin 7..0 = line 24..31.
// - each pull-up bit enables its pin's resistor when one.
// - ports 1,2 pull-up forced off in push-pull, or in code 11 on pins with a function.
// - reset clears all mode and pull-up bits: inputs, no pull-ups.
`timescale 1ns/1ps
module port_pin_config (
    // clock and reset
    input  wire logic                           sys_clk,
    input  wire logic                           rst_n,
    // cpu register access
    input  wire logic [7:0]                     reg_addr,
    input  wire logic                           reg_wr,
    input  wire logic [port_cfg_pkg::REG_W-1:0] reg_wdata,
    input  wire logic                           reg_rd,
    output logic      [port_cfg_pkg::REG_W-1:0] reg_rdata,
    // port data latches
    input  wire logic [7:0]                     port0_data,
    input  wire logic [7:0]                     port1_data,
    input  wire logic [7:0]                     port2_data,
    // alternate function sources
    input  wire logic                           buzzer_output,
    input  wire logic                           clock_output,
    input  wire logic                           timer_b_output,
    input  wire logic                           timer_a_output,
    input  wire logic                           serial_data_out,
    input  wire logic                           serial_clock_out,
    input  wire logic                           serial_clock_oe,
    input  wire logic [7:0]                     lcd_segment_lines,
    // pad inputs
    input  wire logic [7:0]                     port0_pad_in,
    input  wire logic [7:0]                     port1_pad_in,
    // pad controls
    output logic      [7:0]                     port0_pad_out,
    output logic      [7:0]                     port0_pad_oe,
    output logic      [7:0]                     port0_pullup_on,
    output logic      [7:0]                     port1_pad_out,
    output logic      [7:0]                     port1_pad_oe,
    output logic      [7:0]                     port1_pullup_on,
    output logic      [7:0]                     port2_pad_out,
    output logic      [7:0]                     port2_pad_oe,
    output logic      [7:0]                     port2_pullup_on,
    // inputs returned to peripherals
    output logic                                timer1_ext_clock_in,
    output logic                                serial_clock_in
);
    import port_cfg_pkg::*;

    logic [REG_W-1:0]       reg_val    [NUM_REGS];
    logic [NUM_REGS-1:0]    wr_sel;
    logic [NUM_REGS-1:0]    rd_sel;
    logic [REG_W-1:0]       rdata_ff;
    logic [REG_W-1:0]       nxt_rdata;
    logic                   timer1_clk_ff;
    logic                   nxt_timer1_clk;
    logic                   sck_in_ff;
    logic                   nxt_sck_in;
    logic [2:0][15:0]       port_mode;
    logic [2:0][7:0]        port_pu;
    logic [2:0][7:0]        port_dat;
    logic [2:0][7:0]        port_alt;
    logic [2:0][7:0]        port_alt_oe;
    logic [2:0][7:0]        pad_out_v;
    logic [2:0][7:0]        pad_oe_v;
    logic [2:0][7:0]        pu_on_v;

    // address to one-hot register select, shared by read and write
    function automatic logic [NUM_REGS-1:0] addr_hit(input logic [7:0] a);
        logic [NUM_REGS-1:0] hit;
        hit = '0;
        for (int r = 0; r < NUM_REGS; r++) begin
            hit[r] = (a == REG_ADDR[r]);
        end
        return hit;
    endfunction

    assign wr_sel = reg_wr ? addr_hit(reg_addr) : '0;
    assign rd_sel = addr_hit(reg_addr);

    genvar r;
    generate
        for (r = 0; r < NUM_REGS; r++) begin : g_reg
            config_reg u_reg (
                .sys_clk (sys_clk),
                .rst_n   (rst_n),
                .wr_en   (wr_sel[r]),
                .wr_data (reg_wdata),
                .value   (reg_val[r])
            );
        end
    endgenerate

    // read mux, unmapped addresses return zero, data held between reads
    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            nxt_rdata = '0;
            for (int k = 0; k < NUM_REGS; k++) begin
                if (rd_sel[k]) begin
                    nxt_rdata = reg_val[k];
                end
            end
        end
    end

    // sampled pad inputs for the timer and serial clocks
    always_comb begin
        nxt_timer1_clk = port0_pad_in[3] & (port_mode[0][7:6] == MODE_INPUT);
        nxt_sck_in     = port1_pad_in[0] & ((port_mode[1][1:0] == MODE_INPUT) |
                                            (port_mode[1][1:0] == MODE_ALT));
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff      <= REG_RESET;
            timer1_clk_ff <= 1'b0;
            sck_in_ff     <= 1'b0;
        end else begin
            rdata_ff      <= nxt_rdata;
            timer1_clk_ff <= nxt_timer1_clk;
            sck_in_ff     <= nxt_sck_in;
        end
    end

    assign reg_rdata           = rdata_ff;
    assign timer1_ext_clock_in = timer1_clk_ff;
    assign serial_clock_in     = sck_in_ff;

    // gather configuration per port; high byte holds pins 7..4
    always_comb begin
        port_mode[0] = {reg_val[IDX_P0_MODE_HIGH], reg_val[IDX_P0_MODE_LOW]};
        port_mode[1] = {reg_val[IDX_P1_MODE_HIGH], reg_val[IDX_P1_MODE_LOW]};
        port_mode[2] = {reg_val[IDX_P2_MODE_HIGH], reg_val[IDX_P2_MODE_LOW]};
        port_pu[0]   = reg_val[IDX_P0_PULLUP];
        port_pu[1]   = reg_val[IDX_P1_PULLUP];
        port_pu[2]   = reg_val[IDX_P2_PULLUP];
        port_dat[0]  = port0_data;
        port_dat[1]  = port1_data;
        port_dat[2]  = port2_data;
    end

    // alternate sources per pin; segment order is reversed
    always_comb begin
        port_alt[0]    = {buzzer_output, clock_output, timer_b_output,
                          timer_a_output, 4'h0};
        port_alt_oe[0] = 8'hF0;
        port_alt[1]    = {6'h00, serial_data_out, serial_clock_out};
        port_alt_oe[1] = {6'h00, 1'b1, serial_clock_oe};
        port_alt_oe[2] = 8'hFF;
        for (int k = 0; k < 8; k++) begin
            port_alt[2][k] = lcd_segment_lines[7-k];
        end
    end

    genvar p, i;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            for (i = 0; i < 8; i++) begin : g_pin
                port_pin_cell #(
                    .ALT_EN      (ALT_MASK[p][i]),
                    .AUTO_PU_OFF (AUTO_PU_MASK[p][i])
                ) u_cell (
                    .mode       (port_mode[p][2*i+1:2*i]),
                    .pullup_bit (port_pu[p][i]),
                    .data_out   (port_dat[p][i]),
                    .alt_out    (port_alt[p][i]),
                    .alt_oe     (port_alt_oe[p][i]),
                    .pad_out    (pad_out_v[p][i]),
                    .pad_oe     (pad_oe_v[p][i]),
                    .pullup_on  (pu_on_v[p][i]),
                    .alt_active ()
                );
            end
        end
    endgenerate

    // pad controls follow the flops combinationally, no extra latency
    assign port0_pad_out   = pad_out_v[0];
    assign port0_pad_oe    = pad_oe_v[0];
    assign port0_pullup_on = pu_on_v[0];
    assign port1_pad_out   = pad_out_v[1];
    assign port1_pad_oe    = pad_oe_v[1];
    assign port1_pullup_on = pu_on_v[1];
    assign port2_pad_out   = pad_out_v[2];
    assign port2_pad_oe    = pad_oe_v[2];
    assign port2_pullup_on = pu_on_v[2];

    // checks on the mode decode and register behaviour
    a_write_takes_effect:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr && (reg_addr == ADDR_P1_PULLUP)
        |=> reg_val[IDX_P1_PULLUP] == $past(reg_wdata))
    else $error("pull-up write not stored on next edge");

    a_open_drain_p0:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        port_mode[0][1:0] == MODE_OPEN_DRAIN
        |-> !port0_pad_out[0] && (port0_pad_oe[0] == !port0_data[0]))
    else $error("open-drain pin 0.0 drives wrongly");

    a_push_pull_p1:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        port_mode[1][15:14] == MODE_PUSH_PULL
        |-> port1_pad_oe[7] && (port1_pad_out[7] == port1_data[7]))
    else $error("push-pull pin 1.7 not driving data");

    a_buzzer_route:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        port_mode[0][15:14] == MODE_ALT
        |-> port0_pad_oe[7] && (port0_pad_out[7] == buzzer_output))
    else $error("buzzer not routed to pin 0.7");

    a_unused_alt_idle:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        port_mode[0][1:0] == MODE_ALT |-> !port0_pad_oe[0])
    else $error("unassigned code 11 drives pin 0.0");

    a_unused_alt_p1:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        port_mode[1][5:4] == MODE_ALT |-> !port1_pad_oe[2])
    else $error("unassigned code 11 drives pin 1.2");

    a_serial_out_route:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        port_mode[1][3:2] == MODE_ALT
        |-> port1_pad_oe[1] && (port1_pad_out[1] == serial_data_out))
    else $error("serial data not routed to pin 1.1");

    a_input_p2_idle:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        port_mode[2][9:8] == MODE_INPUT |-> !port2_pad_oe[4])
    else $error("input pin 2.4 is driven");

    a_segment_order:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        port_mode[2][15:14] == MODE_ALT && port_mode[2][1:0] == MODE_ALT
        |-> port2_pad_out[7] == lcd_segment_lines[0]
            && port2_pad_out[0] == lcd_segment_lines[7])
    else $error("segment lines mapped in wrong order");

    a_pullup_follow_p0:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr && (reg_addr == ADDR_P0_PULLUP)
        |=> port0_pullup_on == $past(reg_wdata))
    else $error("port 0 pull-ups do not follow their bits");

    a_pullup_auto_off:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        port_mode[1][1] |-> !port1_pullup_on[0])
    else $error("pin 1.0 pull-up on while driven");

    a_reset_clears:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> (port0_pad_oe == 8'h00) && (port1_pullup_on == 8'h00)
            && (port_mode[2] == 16'h0000) && (reg_rdata == 8'h00))
    else $error("configuration not cleared by reset");

    // remaining routes, open-drain pin 2.2, pull-ups that must survive non-driving modes, and a readback
    a_clock_out_route:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        port_mode[0][13:12] == MODE_ALT |-> port0_pad_oe[6] && (port0_pad_out[6] == clock_output))
    else $error("clock output not routed to pin 0.6");

    a_timer_b_route:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        port_mode[0][11:10] == MODE_ALT
        |-> port0_pad_oe[5] && (port0_pad_out[5] == timer_b_output))
    else $error("timer b output not routed to pin 0.5");

    a_timer_a_route:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        port_mode[0][9:8] == MODE_ALT |-> port0_pad_oe[4] && (port0_pad_out[4] == timer_a_output))
    else $error("timer a output not routed to pin 0.4");

    a_serial_clock_route:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        port_mode[1][1:0] == MODE_ALT
        |-> (port1_pad_oe[0] == serial_clock_oe) && (port1_pad_out[0] == serial_clock_out))
    else $error("serial clock not routed to pin 1.0");

    a_open_drain_p2:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        port_mode[2][5:4] == MODE_OPEN_DRAIN
        |-> !port2_pad_out[2] && (port2_pad_oe[2] == !port2_data[2]))
    else $error("open-drain pin 2.2 drives wrongly");

    a_pullup_keep_p1:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        port_mode[1][3:2] == MODE_OPEN_DRAIN |-> port1_pullup_on[1] == port_pu[1][1])
    else $error("pin 1.1 pull-up dropped in open-drain mode");

    a_pullup_keep_unused:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        port_mode[1][5:4] == MODE_ALT |-> port1_pullup_on[2] == port_pu[1][2])
    else $error("pin 1.2 pull-up dropped without an alternate function");

    a_read_returns:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_rd && (reg_addr == ADDR_P2_MODE_LOW)
        |=> reg_rdata == $past(reg_val[IDX_P2_MODE_LOW]))
    else $error("read of port 2 low mode byte returns wrong data");

endmodule

// >>> rtl/port_cfg_pkg.sv
// constants for the three-port pin configuration block
package port_cfg_pkg;

    // register data width and count
    localparam int REG_W    = 8;
    localparam int NUM_REGS = 9;
    localparam int NUM_PORTS = 3;
    localparam int MODE_W   = 2;

    // register indices into the configuration array
    localparam int IDX_P0_MODE_HIGH = 0;
    localparam int IDX_P0_MODE_LOW  = 1;
    localparam int IDX_P0_PULLUP    = 2;
    localparam int IDX_P1_MODE_HIGH = 3;
    localparam int IDX_P1_MODE_LOW  = 4;
    localparam int IDX_P1_PULLUP    = 5;
    localparam int IDX_P2_MODE_HIGH = 6;
    localparam int IDX_P2_MODE_LOW  = 7;
    localparam int IDX_P2_PULLUP    = 8;

    // register addresses on the cpu register bus
    localparam logic [7:0] ADDR_P0_MODE_HIGH = 8'hD0;
    localparam logic [7:0] ADDR_P0_MODE_LOW  = 8'hE5;
    localparam logic [7:0] ADDR_P0_PULLUP    = 8'hE6;
    localparam logic [7:0] ADDR_P1_MODE_HIGH = 8'hE7;
    localparam logic [7:0] ADDR_P1_MODE_LOW  = 8'hE8;
    localparam logic [7:0] ADDR_P1_PULLUP    = 8'hF9;
    localparam logic [7:0] ADDR_P2_MODE_HIGH = 8'hD1;
    localparam logic [7:0] ADDR_P2_MODE_LOW  = 8'hD2;
    localparam logic [7:0] ADDR_P2_PULLUP    = 8'hEC;

    // address table ordered by register index
    localparam logic [7:0] REG_ADDR [NUM_REGS] = '{
        ADDR_P0_MODE_HIGH, ADDR_P0_MODE_LOW, ADDR_P0_PULLUP,
        ADDR_P1_MODE_HIGH, ADDR_P1_MODE_LOW, ADDR_P1_PULLUP,
        ADDR_P2_MODE_HIGH, ADDR_P2_MODE_LOW, ADDR_P2_PULLUP
    };

    // every configuration register clears to zero
    localparam logic [7:0] REG_RESET = 8'h00;

    // two-bit pin mode codes
    localparam logic [1:0] MODE_INPUT      = 2'h0;
    localparam logic [1:0] MODE_OPEN_DRAIN = 2'h1;
    localparam logic [1:0] MODE_PUSH_PULL  = 2'h2;
    localparam logic [1:0] MODE_ALT        = 2'h3;

    // pins with a real alternate function, per port
    localparam logic [7:0] ALT_MASK [NUM_PORTS] = '{8'hF0, 8'h03, 8'hFF};

    // pins whose pull-up is dropped in push-pull, or in alternate mode where ALT_MASK gives the pin a function
    localparam logic [7:0] AUTO_PU_MASK [NUM_PORTS] = '{8'h00, 8'hFF, 8'hFF};

endpackage

// >>> rtl/config_reg.sv
// one software-writable configuration byte
`timescale 1ns/1ps
module config_reg (
    // clock and reset
    input  wire logic                           sys_clk,
    input  wire logic                           rst_n,
    // write side
    input  wire logic                           wr_en,
    input  wire logic [port_cfg_pkg::REG_W-1:0] wr_data,
    // stored value
    output logic      [port_cfg_pkg::REG_W-1:0] value
);
    import port_cfg_pkg::*;

    logic [REG_W-1:0] value_ff;
    logic [REG_W-1:0] nxt_value;

    // a write lands on the next edge, otherwise hold
    always_comb begin
        nxt_value = wr_en ? wr_data : value_ff;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            value_ff <= REG_RESET;
        end else begin
            value_ff <= nxt_value;
        end
    end

    assign value = value_ff;

endmodule

// >>> rtl/port_pin_cell.sv
// per-pin mode decode, pad drive and pull-up control
`timescale 1ns/1ps
module port_pin_cell #(
    parameter bit ALT_EN      = 1'b0,
    parameter bit AUTO_PU_OFF = 1'b0
) (
    // configuration
    input  wire logic [port_cfg_pkg::MODE_W-1:0] mode,
    input  wire logic                            pullup_bit,
    // sources
    input  wire logic                            data_out,
    input  wire logic                            alt_out,
    input  wire logic                            alt_oe,
    // pad side
    output logic                                 pad_out,
    output logic                                 pad_oe,
    output logic                                 pullup_on,
    output logic                                 alt_active
);
    import port_cfg_pkg::*;

    // open drain only ever pulls low; a high data bit releases the pad
    always_comb begin
        pad_out    = 1'b0;
        pad_oe     = 1'b0;
        alt_active = 1'b0;
        unique case (mode)
            MODE_INPUT: begin
                pad_oe = 1'b0;
            end
            MODE_OPEN_DRAIN: begin
                pad_oe = ~data_out;
            end
            MODE_PUSH_PULL: begin
                pad_out = data_out;
                pad_oe  = 1'b1;
            end
            MODE_ALT: begin
                // unassigned pins stay undriven, like input
                if (ALT_EN) begin
                    alt_active = 1'b1;
                    pad_out    = alt_out;
                    pad_oe     = alt_oe;
                end
            end
        endcase
        // resistor would fight an actively driven pad, so drop it there
        pullup_on = pullup_bit &
                    ~(AUTO_PU_OFF & ((mode == MODE_PUSH_PULL) | alt_active));
    end

endmodule

// >>> verification/tb.sv
// self-checking bench for the three-port pin configuration block
`timescale 1ns/1ps
module tb;
    import port_cfg_pkg::*;
    logic        sys_clk   = 1'b0;
    logic        rst_n     = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic        reg_wr    = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_rd    = 1'b0;
    logic [7:0]  reg_rdata;
    logic [7:0]  pdat [3]  = '{default: 8'h00};
    logic [7:0]  pin  [2]  = '{default: 8'h00};
    logic [3:0]  p0_alt    = 4'h0;
    logic [2:0]  p1_alt    = 3'h0;
    logic [7:0]  lcd       = 8'h00;
    logic [7:0]  pout [3];
    logic [7:0]  poe  [3];
    logic [7:0]  ppu  [3];
    logic        t1_in;
    logic        sck_in;
    logic [7:0]  sh [NUM_REGS] = '{default: 8'h00};
    logic [73:0] rd_q  [$];
    logic [73:0] pad_q [$];
    logic [73:0] msk_q [$];
    logic        rd_seen   = 1'b0;
    logic        pad_stb   = 1'b0;
    int          err_count = 0;
    int          cmp_count = 0;
    int          seed      = 12269;
    wire  [73:0] pad_vec = {t1_in, sck_in, pout[2], poe[2], ppu[2], pout[1], poe[1], ppu[1],
                            pout[0], poe[0], ppu[0]};

    port_pin_config u_port_pin_config (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .port0_data(pdat[0]), .port1_data(pdat[1]), .port2_data(pdat[2]),
        .buzzer_output(p0_alt[3]), .clock_output(p0_alt[2]), .timer_b_output(p0_alt[1]),
        .timer_a_output(p0_alt[0]), .serial_data_out(p1_alt[2]),
        .serial_clock_out(p1_alt[1]), .serial_clock_oe(p1_alt[0]), .lcd_segment_lines(lcd),
        .port0_pad_in(pin[0]), .port1_pad_in(pin[1]),
        .port0_pad_out(pout[0]), .port0_pad_oe(poe[0]), .port0_pullup_on(ppu[0]),
        .port1_pad_out(pout[1]), .port1_pad_oe(poe[1]), .port1_pullup_on(ppu[1]),
        .port2_pad_out(pout[2]), .port2_pad_oe(poe[2]), .port2_pullup_on(ppu[2]),
        .timer1_ext_clock_in(t1_in), .serial_clock_in(sck_in)
    );

    // 100 ns period
    always #50 sys_clk = ~sys_clk;

    task automatic check(string name, logic [73:0] got, logic [73:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // expected {out, oe, pullup} of one pin; out only counts while driven
    // pin decode model
    function automatic logic [2:0] pin_exp(int p, int i, logic [1:0] md, logic d, logic pu,
                                           logic [3:0] a0, logic [2:0] a1, logic [7:0] l);
        logic alt;
        logic ao;
        logic aoe;
        logic drop;
        alt  = (p == 0 && i > 3) || (p == 1 && i < 2) || p == 2;
        ao   = (p == 0) ? a0[i % 4] : (p == 1) ? ((i == 1) ? a1[2] : a1[1]) : l[7 - i];
        aoe  = (p == 1 && i == 0) ? a1[0] : 1'b1;
        drop = p != 0 && (md == 2'h2 || (md == 2'h3 && alt));
        pin_exp[0] = pu & ~drop;
        case (md)
            2'h0:    pin_exp[2:1] = 2'b00;
            2'h1:    pin_exp[2:1] = {1'b0, ~d};
            2'h2:    pin_exp[2:1] = {d, 1'b1};
            default: pin_exp[2:1] = alt ? {ao, aoe} : 2'b00;
        endcase
    endfunction

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        rd_q.push_back({66'h0, e});
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
    endtask

    // random pad data and alternate sources, then one pad snapshot
    task automatic step();
        logic [7:0]  nd [3];
        logic [7:0]  np [2];
        logic [3:0]  na;
        logic [2:0]  nb;
        logic [7:0]  nl;
        logic [73:0] e;
        logic [73:0] m;
        logic [2:0]  r;
        logic [1:0]  md;
        for (int p = 0; p < 3; p++) nd[p] = 8'($random(seed));
        for (int p = 0; p < 2; p++) np[p] = 8'($random(seed));
        na = 4'($random(seed));
        nb = 3'($random(seed));
        nl = 8'($random(seed));
        e  = '0;
        m  = '0;
        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 8; i++) begin
                md = (i > 3) ? sh[3*p][2*i-8 +: 2] : sh[3*p+1][2*i +: 2];
                r  = pin_exp(p, i, md, nd[p][i], sh[3*p+2][i], na, nb, nl);
                e[24*p+16+i] = r[2] & r[1];
                e[24*p+8+i]  = r[1];
                e[24*p+i]    = r[0];
                m[24*p+16+i] = r[1];
                m[24*p+8+i]  = 1'b1;
                m[24*p+i]    = 1'b1;
            end
        end
        // clock returns only pass the pad in their input-capable modes
        e[73] = (sh[1][7:6] == 2'h0) & np[0][3];
        e[72] = (sh[4][1:0] == 2'h0 || sh[4][1:0] == 2'h3) & np[1][0];
        m[73:72] = 2'h3;
        @(posedge sys_clk);
        for (int p = 0; p < 3; p++) pdat[p] <= nd[p];
        for (int p = 0; p < 2; p++) pin[p] <= np[p];
        p0_alt <= na;
        p1_alt <= nb;
        lcd    <= nl;
        pad_q.push_back(e);
        msk_q.push_back(m);
        @(posedge sys_clk);
        pad_stb <= 1'b1;
        @(posedge sys_clk);
        pad_stb <= 1'b0;
    endtask

    // read answer lands one cycle after the strobe edge
    always @(posedge sys_clk) begin
        rd_seen <= reg_rd;
    end

    // watcher: results are taken mid-cycle, once everything has settled
    always @(negedge sys_clk) begin
        if (rd_seen) begin
            check("reg_rdata", {66'h0, reg_rdata}, rd_q.pop_front());
        end
        if (pad_stb) begin
            check("pads", pad_vec & msk_q.pop_front(), pad_q.pop_front());
        end
    end

    // hang guard, a generous margin over the expected run
    initial begin
        #(100 * 20000);
        err_count++;
        give_verdict();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int pass = 0; pass < 2; pass++) begin
            for (int k = 0; k < NUM_REGS; k++) rd(REG_ADDR[k], 8'h00);
            step();
            if (pass == 0) begin
                // every code on every pin with all pull-ups requested
                for (int c = 0; c < 4; c++) begin
                    for (int k = 0; k < NUM_REGS; k++) begin
                        sh[k] = (k % 3 == 2) ? 8'hFF : {4{c[1:0]}};
                        wr(REG_ADDR[k], sh[k]);
                    end
                    repeat (3) step();
                end
                // random settings, readback, unmapped place ignored
                repeat (25) begin
                    for (int k = 0; k < NUM_REGS; k++) begin
                        sh[k] = 8'($random(seed));
                        wr(REG_ADDR[k], sh[k]);
                    end
                    wr(8'h01, 8'hA5);
                    for (int k = 0; k < NUM_REGS; k++) rd(REG_ADDR[k], sh[k]);
                    rd(8'h01, 8'h00);
                    repeat (2) step();
                end
                // second reset in mid-run
                @(posedge sys_clk);
                rst_n <= 1'b0;
                @(posedge sys_clk);
                rst_n <= 1'b1;
                for (int k = 0; k < NUM_REGS; k++) sh[k] = 8'h00;
            end
        end
        give_verdict();
    end
endmodule
